//--- shared/ccp_pkg.sv
// Constants and types shared by the capture/compare timer
package ccp_pkg;
	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int NCH = 2;
	localparam int AW  = 6;

	// ********************************************************
	// Register byte addresses, one byte per 32-bit word
	// ********************************************************
	localparam logic [AW-1:0] A_MAIN_CTRL = 6'h00;
	localparam logic [AW-1:0] A_CNT_HI    = 6'h04;
	localparam logic [AW-1:0] A_CNT_LO    = 6'h08;
	localparam logic [AW-1:0] A_MOD_HI    = 6'h0c;
	localparam logic [AW-1:0] A_MOD_LO    = 6'h10;
	localparam logic [AW-1:0] A_CH_BASE   = 6'h14;
	localparam logic [AW-1:0] A_CH_STRIDE = 6'h0c;
	localparam logic [AW-1:0] A_CH_SC     = 6'h00;
	localparam logic [AW-1:0] A_CH_VH     = 6'h04;
	localparam logic [AW-1:0] A_CH_VL     = 6'h08;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int F_TOF    = 7;
	localparam int F_OVERFLOW_IRQ_ENABLE   = 6;
	localparam int F_CENTER_ALIGNED_SELECT  = 5;
	localparam int F_CLKS   = 3;
	localparam int F_CHF    = 7;
	localparam int F_CHIE   = 6;
	localparam int F_MSB    = 5;
	localparam int F_MSA    = 4;
	localparam int F_ELS    = 2;

	// ********************************************************
	// Codes and values
	// ********************************************************
	localparam logic [1:0]  CLK_OFF   = 2'h0;
	localparam logic [1:0]  CLK_BUS   = 2'h1;
	localparam logic [1:0]  CLK_FIXED = 2'h2;
	localparam logic [1:0]  CLK_EXT   = 2'h3;
	localparam logic [1:0]  ELS_NONE  = 2'h0;
	localparam logic [1:0]  ELS_RISE  = 2'h1;
	localparam logic [1:0]  ELS_FALL  = 2'h2;
	localparam logic [1:0]  ELS_SET   = 2'h3;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [15:0] CNT_MAX   = 16'hffff;
	localparam logic        WAIT_IDLE = 1'b1;

	// ********************************************************
	// Bus request and state carriers
	// ********************************************************
	typedef struct packed {
		logic [AW-1:0] address;
		logic          read;
		logic          write;
		logic [31:0]   writedata;
		logic [3:0]    byteenable;
	} ccp_bus_s;

	typedef struct packed {
		logic        msb;
		logic        msa;
		logic [1:0]  els;
		logic        ie;
		logic        flag;
		logic        arm;
		logic [15:0] val;
		logic [15:0] vbuf;
		logic        lat;
		logic        first_hi;
		logic        wh;
		logic        wl;
		logic        pin;
		logic        oe;
		logic        irq;
		logic [2:0]  sync;
	} ccp_ch_s;

	typedef struct packed {
		logic [1:0]    clks;
		logic          center_aligned_select;
		logic          overflow_irq_enable;
		logic          overflow_flag;
		logic          tof_arm;
		logic          tof_irq;
		logic [15:0]   cnt;
		logic          dir_down;
		logic [15:0]   mod;
		logic [15:0]   mod_buf;
		logic          mod_wh;
		logic          mod_wl;
		logic          cnt_lat;
		logic          cnt_first_hi;
		logic [15:0]   cnt_buf;
		logic [2:0]    fix_sync;
		logic [2:0]    ext_sync;
		logic          wait_r;
		logic [31:0]   rdata;
		ccp_ch_s [NCH-1:0] ch;
	} ccp_state_s;
endpackage

//--- src/ccp_timer.sv
// Capture/compare timer counter with Avalon-MM register access
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module ccp_timer
	import ccp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  ce_i,
	// Register bus
	input  wire ccp_pkg::ccp_bus_s     bus_i,
	output logic [31:0]                readdata_o,
	output logic                       waitrequest_o,
	// System modes
	input  wire logic                  dbg_halt_i,
	input  wire logic                  stop_i,
	// Clock sources
	input  wire logic                  fix_clk_i,
	input  wire logic                  ext_clk_i,
	// Channel pins
	input  wire logic [ccp_pkg::NCH-1:0] ch_pin_i,
	output logic [ccp_pkg::NCH-1:0]    ch_pin_o,
	output logic [ccp_pkg::NCH-1:0]    ch_oe_o,
	// Interrupt requests
	output logic                       tof_irq_o,
	output logic [ccp_pkg::NCH-1:0]    ch_irq_o
);
	import ccp_pkg::*;

	ccp_state_s st_reg;
	ccp_state_s st_next;
	logic       tick;
	logic [15:0] tc;
	logic       cnt_wr;
	logic       tof_ev;
	logic [NCH-1:0] ch_ev;

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		logic       acc;
		logic       rd0;
		logic [7:0] rb;
		logic [7:0] wb;
		logic       src;
		logic [AW-1:0] cb;
		logic       cap;
		logic       ocm;
		logic       epwm;
		logic       edge_hit;
		logic       rise;
		logic       fall;
		logic       match;
		acc = 1'b0;
		rd0 = 1'b0;
		rb = 8'h00;
		wb = bus_i.writedata[7:0];
		src = 1'b0;
		cb = A_CH_BASE;
		cap = 1'b0;
		ocm = 1'b0;
		epwm = 1'b0;
		edge_hit = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		match = 1'b0;
		st_next = st_reg;
		tof_ev = 1'b0;
		ch_ev = '0;
		cnt_wr = 1'b0;

		// Pins go through two flops before any edge detector sees them
		st_next.fix_sync = {st_reg.fix_sync[1:0], fix_clk_i};
		st_next.ext_sync = {st_reg.ext_sync[1:0], ext_clk_i};
		for (int i = 0; i < NCH; i++) begin
			st_next.ch[i].sync = {st_reg.ch[i].sync[1:0], ch_pin_i[i]};
		end

		// Clock source and suspension
		case (st_reg.clks)
			CLK_BUS:   src = 1'b1;
			CLK_FIXED: src = st_reg.fix_sync[1] & ~st_reg.fix_sync[2];
			CLK_EXT:   src = st_reg.ext_sync[1] & ~st_reg.ext_sync[2];
			default:   src = 1'b0;
		endcase
		tick = src & ~dbg_halt_i & ~stop_i;
		tc = (st_reg.mod == CNT_ZERO) ? CNT_MAX : st_reg.mod;

		// Counter
		if (tick) begin
			if (!st_reg.center_aligned_select) begin
				st_next.dir_down = 1'b0;
				if (st_reg.cnt == tc) begin
					st_next.cnt = CNT_ZERO;
					tof_ev = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + CNT_ONE;
				end
			end else if (!st_reg.dir_down) begin
				if (st_reg.cnt == st_reg.mod) begin
					st_next.dir_down = 1'b1;
					st_next.cnt = st_reg.mod - CNT_ONE;
					tof_ev = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + CNT_ONE;
				end
			end else if (st_reg.cnt == CNT_ZERO) begin
				st_next.dir_down = 1'b0;
				st_next.cnt = CNT_ONE;
			end else begin
				st_next.cnt = st_reg.cnt - CNT_ONE;
			end
		end

		// Modulus: immediate in up mode, at period end in center mode
		if (st_reg.mod_wh && st_reg.mod_wl && (!st_reg.center_aligned_select || tof_ev)) begin
			st_next.mod = st_reg.mod_buf;
			st_next.mod_wh = 1'b0;
			st_next.mod_wl = 1'b0;
		end

		// Channels
		for (int i = 0; i < NCH; i++) begin
			cap = !st_reg.center_aligned_select && !st_reg.ch[i].msb && !st_reg.ch[i].msa;
			ocm = !st_reg.center_aligned_select && !st_reg.ch[i].msb && st_reg.ch[i].msa;
			epwm = !st_reg.center_aligned_select && st_reg.ch[i].msb;
			rise = st_reg.ch[i].sync[1] & ~st_reg.ch[i].sync[2];
			fall = ~st_reg.ch[i].sync[1] & st_reg.ch[i].sync[2];
			case (st_reg.ch[i].els)
				ELS_RISE: edge_hit = rise;
				ELS_FALL: edge_hit = fall;
				ELS_SET:  edge_hit = rise | fall;
				default:  edge_hit = 1'b0;
			endcase
			match = tick && !cap && (st_reg.cnt == st_reg.ch[i].val);
			st_next.ch[i].oe = !cap && (st_reg.ch[i].els != ELS_NONE);
			if (cap && edge_hit) begin
				st_next.ch[i].val = st_reg.cnt;
				ch_ev[i] = 1'b1;
			end
			if (match) begin
				ch_ev[i] = 1'b1;
			end
			if (ocm && match) begin
				case (st_reg.ch[i].els)
					ELS_RISE: st_next.ch[i].pin = ~st_reg.ch[i].pin;
					ELS_FALL: st_next.ch[i].pin = 1'b0;
					ELS_SET:  st_next.ch[i].pin = 1'b1;
					default:  st_next.ch[i].pin = st_reg.ch[i].pin;
				endcase
			end
			// PWM polarity follows the low edge select bit
			if (epwm && tof_ev) begin
				st_next.ch[i].pin = ~st_reg.ch[i].els[0];
			end else if (epwm && match) begin
				st_next.ch[i].pin = st_reg.ch[i].els[0];
			end else if (st_reg.center_aligned_select && match) begin
				st_next.ch[i].pin = st_reg.dir_down ^ st_reg.ch[i].els[0];
			end
			// Buffered value loads at once in output compare mode, at a safe point of the period in PWM modes
			if (st_reg.ch[i].wh && st_reg.ch[i].wl && !cap) begin
				if (ocm || (epwm && st_reg.cnt == CNT_ZERO) || (st_reg.center_aligned_select && tof_ev)) begin
					st_next.ch[i].val = st_reg.ch[i].vbuf;
					st_next.ch[i].wh = 1'b0;
					st_next.ch[i].wl = 1'b0;
				end
			end
		end

		// ********************************************************
		// Register bus: read side effects on the first cycle,
		// write on the accepting edge
		// ********************************************************
		st_next.wait_r = !(bus_i.read || bus_i.write) || !st_reg.wait_r;
		rd0 = bus_i.read && st_reg.wait_r;
		acc = bus_i.write && !st_reg.wait_r && bus_i.byteenable[0];
		if (bus_i.address == A_MAIN_CTRL) begin
			rb = {st_reg.overflow_flag, st_reg.overflow_irq_enable, st_reg.center_aligned_select, st_reg.clks, 3'h0};
			if (rd0 && st_reg.overflow_flag) begin
				st_next.tof_arm = 1'b1;
			end
			if (acc) begin
				st_next.overflow_irq_enable = wb[F_OVERFLOW_IRQ_ENABLE];
				st_next.center_aligned_select = wb[F_CENTER_ALIGNED_SELECT];
				st_next.clks = wb[F_CLKS+:2];
				st_next.mod_wh = 1'b0;
				st_next.mod_wl = 1'b0;
				if (!wb[F_TOF] && st_reg.tof_arm) begin
					st_next.overflow_flag = 1'b0;
				end
				st_next.tof_arm = 1'b0;
			end
		end else if (bus_i.address == A_CNT_HI || bus_i.address == A_CNT_LO) begin
			// A snapshot stays until the other byte is read or the counter is written
			rb = (bus_i.address == A_CNT_HI) ? st_reg.cnt[15:8] : st_reg.cnt[7:0];
			if (st_reg.cnt_lat) begin
				rb = (bus_i.address == A_CNT_HI) ? st_reg.cnt_buf[15:8] : st_reg.cnt_buf[7:0];
			end
			if (rd0 && !st_reg.cnt_lat) begin
				st_next.cnt_lat = 1'b1;
				st_next.cnt_buf = st_reg.cnt;
				st_next.cnt_first_hi = (bus_i.address == A_CNT_HI);
			end else if (rd0 && (st_reg.cnt_first_hi != (bus_i.address == A_CNT_HI))) begin
				st_next.cnt_lat = 1'b0;
			end
			if (acc) begin
				cnt_wr = 1'b1;
				st_next.cnt = CNT_ZERO;
				st_next.dir_down = 1'b0;
				st_next.cnt_lat = 1'b0;
			end
		end else if (bus_i.address == A_MOD_HI) begin
			rb = st_reg.mod[15:8];
			if (acc) begin
				st_next.mod_buf[15:8] = wb;
				st_next.mod_wh = 1'b1;
			end
		end else if (bus_i.address == A_MOD_LO) begin
			rb = st_reg.mod[7:0];
			if (acc) begin
				st_next.mod_buf[7:0] = wb;
				st_next.mod_wl = 1'b1;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				cb = A_CH_BASE + AW'(i) * A_CH_STRIDE;
				cap = !st_reg.center_aligned_select && !st_reg.ch[i].msb && !st_reg.ch[i].msa;
				if (bus_i.address == cb + A_CH_SC) begin
					rb = {st_reg.ch[i].flag, st_reg.ch[i].ie, st_reg.ch[i].msb, st_reg.ch[i].msa,
						st_reg.ch[i].els, 2'h0};
					if (rd0 && st_reg.ch[i].flag) begin
						st_next.ch[i].arm = 1'b1;
					end
					if (acc) begin
						st_next.ch[i].ie = wb[F_CHIE];
						st_next.ch[i].msb = wb[F_MSB];
						st_next.ch[i].msa = wb[F_MSA];
						st_next.ch[i].els = wb[F_ELS+:2];
						st_next.ch[i].lat = 1'b0;
						st_next.ch[i].wh = 1'b0;
						st_next.ch[i].wl = 1'b0;
						if (!wb[F_CHF] && st_reg.ch[i].arm) begin
							st_next.ch[i].flag = 1'b0;
						end
						st_next.ch[i].arm = 1'b0;
					end
				end else if (bus_i.address == cb + A_CH_VH || bus_i.address == cb + A_CH_VL) begin
					rb = (bus_i.address == cb + A_CH_VH) ? st_reg.ch[i].val[15:8] : st_reg.ch[i].val[7:0];
					if (cap && st_reg.ch[i].lat) begin
						rb = (bus_i.address == cb + A_CH_VH) ? st_reg.ch[i].vbuf[15:8]
							: st_reg.ch[i].vbuf[7:0];
					end
					if (rd0 && cap && !st_reg.ch[i].lat) begin
						st_next.ch[i].lat = 1'b1;
						st_next.ch[i].vbuf = st_reg.ch[i].val;
						st_next.ch[i].first_hi = (bus_i.address == cb + A_CH_VH);
					end else if (rd0 && cap && (st_reg.ch[i].first_hi != (bus_i.address == cb + A_CH_VH))) begin
						st_next.ch[i].lat = 1'b0;
					end
					if (acc && !cap && bus_i.address == cb + A_CH_VH) begin
						st_next.ch[i].vbuf[15:8] = wb;
						st_next.ch[i].wh = 1'b1;
					end else if (acc && !cap) begin
						st_next.ch[i].vbuf[7:0] = wb;
						st_next.ch[i].wl = 1'b1;
					end
				end
			end
		end
		if (rd0) begin
			st_next.rdata = {24'h000000, rb};
		end

		// Events set after the clears so a coincident event survives
		if (tof_ev) begin
			st_next.overflow_flag = 1'b1;
			st_next.tof_arm = 1'b0;
		end
		for (int i = 0; i < NCH; i++) begin
			if (ch_ev[i]) begin
				st_next.ch[i].flag = 1'b1;
				st_next.ch[i].arm = 1'b0;
			end
			st_next.ch[i].irq = st_next.ch[i].flag & st_next.ch[i].ie;
		end
		st_next.tof_irq = st_next.overflow_flag & st_next.overflow_irq_enable;
	end

	// ********************************************************
	// State register
	// ********************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
			st_reg.wait_r <= WAIT_IDLE;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	always_comb begin
		readdata_o = st_reg.rdata;
		waitrequest_o = st_reg.wait_r;
		tof_irq_o = st_reg.tof_irq;
		for (int i = 0; i < NCH; i++) begin
			ch_pin_o[i] = st_reg.ch[i].pin;
			ch_oe_o[i] = st_reg.ch[i].oe;
			ch_irq_o[i] = st_reg.ch[i].irq;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	sequence s_up_wrap;
		ce_i && tick && !cnt_wr && !st_reg.center_aligned_select && st_reg.cnt == tc;
	endsequence
	sequence s_ev_on_clear;
		ce_i && tof_ev && bus_i.write && !st_reg.wait_r;
	endsequence

	a_reset_clk_off: assert property (@(posedge clk_i) $rose(rst_b_i) |-> st_reg.clks == CLK_OFF)
		else $error("clock select not off after reset");
	a_bus_clk_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !cnt_wr && !dbg_halt_i && !stop_i && st_reg.clks == CLK_BUS && !st_reg.center_aligned_select && st_reg.cnt != tc
		|=> st_reg.cnt == $past(st_reg.cnt) + CNT_ONE)
		else $error("bus clock did not step counter");
	a_halt_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(dbg_halt_i || stop_i || !ce_i) && !cnt_wr |=> st_reg.cnt == $past(st_reg.cnt))
		else $error("counter moved while halted");
	a_up_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_up_wrap |=> st_reg.cnt == CNT_ZERO && st_reg.overflow_flag)
		else $error("up count wrap wrong");
	a_updown_turn: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && tick && !cnt_wr && st_reg.center_aligned_select && !st_reg.dir_down && st_reg.cnt == st_reg.mod
		|=> st_reg.dir_down && st_reg.overflow_flag && st_reg.cnt == $past(st_reg.mod) - CNT_ONE)
		else $error("up/down reversal wrong");
	a_tof_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && st_reg.overflow_flag && st_reg.overflow_irq_enable && !(bus_i.write && bus_i.address == A_MAIN_CTRL)
		|=> tof_irq_o)
		else $error("overflow interrupt missing");
	a_cnt_write_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && cnt_wr |=> st_reg.cnt == CNT_ZERO && !st_reg.cnt_lat)
		else $error("counter write did not clear");
	a_event_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_ev_on_clear |=> st_reg.overflow_flag)
		else $error("overflow lost against clear");
	a_capture_copy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && ch_ev[0] && !st_reg.center_aligned_select && !st_reg.ch[0].msb && !st_reg.ch[0].msa
		|=> st_reg.ch[0].val == $past(st_reg.cnt) && st_reg.ch[0].flag)
		else $error("capture did not copy counter");
	a_bus_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && (bus_i.read || bus_i.write) && st_reg.wait_r |=> !waitrequest_o)
		else $error("bus answer late");
endmodule

//--- bench/ccp_pin_model.sv
// External pins model: clock sources and channel pin drivers for the timer
`timescale 1ns/1ps
module ccp_pin_model
	import ccp_pkg::*;
(
	// Clock
	input  wire logic           clk_i,
	// Timer pin outputs
	input  wire logic [NCH-1:0] ch_pin_o,
	input  wire logic [NCH-1:0] ch_oe_o,
	// Sources toward the timer
	output logic                fix_clk_o,
	output logic                ext_clk_o,
	output logic [NCH-1:0]      pin_level_o
);
	import ccp_pkg::*;

	logic [NCH-1:0] drv_reg;

	initial begin
		fix_clk_o = 1'b0;
		ext_clk_o = 1'b0;
		drv_reg   = '0;
	end

	// Wire level: timer wins while it drives, otherwise the far driver
	assign pin_level_o = (ch_oe_o & ch_pin_o) | (~ch_oe_o & drv_reg);

	// Clock pulses 4 high, 5 low: a ninth of the bus rate keeps margin for the synchroniser
	task automatic tick(input logic ext, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			if (ext) ext_clk_o <= 1'b1;
			else fix_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_clk_o <= 1'b0;
			fix_clk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask

	// Held long enough for two sync flops plus edge detect to see it
	task automatic set_pin(input int ch, input logic v);
		@(posedge clk_i);
		drv_reg[ch] <= v;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the capture/compare timer over its register bus
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	import ccp_pkg::*;

	// ************************************************
	// Signals and instances
	// ************************************************
	logic                clk_i;
	logic                rst_b_i;
	ccp_bus_s            bus;
	logic [31:0]         readdata_o;
	logic                waitrequest_o;
	logic                dbg_halt;
	logic                stop;
	logic                fix_clk;
	logic                ext_clk;
	logic [NCH-1:0]      pin_level;
	logic [NCH-1:0]      ch_pin_o;
	logic [NCH-1:0]      ch_oe_o;
	logic                tof_irq_o;
	logic [NCH-1:0]      ch_irq_o;
	int                  err_total;
	int                  tests_run;
	int                  cyc;
	logic [7:0]          q;
	logic [7:0]          h;
	logic [15:0]         v;
	localparam logic [AW-1:0] C0 = A_CH_BASE;
	localparam logic [AW-1:0] C1 = A_CH_BASE + A_CH_STRIDE;
	logic [7:0] cap_exp [4] = '{8'h03, 8'h00, 8'h02, 8'h02};
	logic [15:0] ud_exp [9] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0000,
		16'h0001};
	logic [1:0] oc_els [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
	logic       oc_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	ccp_timer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .bus_i(bus), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .dbg_halt_i(dbg_halt), .stop_i(stop), .fix_clk_i(fix_clk),
		.ext_clk_i(ext_clk), .ch_pin_i(pin_level), .ch_pin_o(ch_pin_o), .ch_oe_o(ch_oe_o),
		.tof_irq_o(tof_irq_o), .ch_irq_o(ch_irq_o));

	ccp_pin_model pm (.clk_i(clk_i), .ch_pin_o(ch_pin_o), .ch_oe_o(ch_oe_o), .fix_clk_o(fix_clk),
		.ext_clk_o(ext_clk), .pin_level_o(pin_level));

	// ************************************************
	// Clock, watchdog and bus tasks
	// ************************************************
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk_i);
		bus <= '{address: a, read: ~w, write: w, writedata: {24'h000000, d}, byteenable: 4'hf};
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		r = readdata_o[7:0];
		bus <= '0;
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [AW-1:0] a, output logic [7:0] r);
		xfer(1'b0, a, 8'h00, r);
	endtask

	task automatic rd_cnt(output logic [15:0] c);
		logic [7:0] hi;
		logic [7:0] lo;
		rd(A_CNT_HI, hi);
		rd(A_CNT_LO, lo);
		c = {hi, lo};
	endtask

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		bus = '0;
		dbg_halt = 1'b0;
		stop = 1'b0;
		rst_b_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(A_MAIN_CTRL, q); `CHK(q, 8'h00)
		pm.tick(0, 2);
		rd_cnt(v); `CHK(v, 16'h0000)
		rd(6'h3c, q); `CHK(q, 8'h00)
		// Fixed, external and bus clock sources, halt and stop, snapshot held across ticks
		wr(A_MAIN_CTRL, 8'h10);
		pm.tick(0, 3);
		rd(A_CNT_HI, q); `CHK(q, 8'h00)
		pm.tick(0, 2);
		rd(A_CNT_LO, q); `CHK(q, 8'h03)
		rd(A_CNT_LO, q); `CHK(q, 8'h05)
		rd(A_CNT_HI, q);
		dbg_halt <= 1'b1;
		pm.tick(0, 1);
		rd_cnt(v); `CHK(v, 16'h0005)
		dbg_halt <= 1'b0;
		pm.tick(0, 1);
		rd_cnt(v); `CHK(v, 16'h0006)
		stop <= 1'b1;
		pm.tick(0, 1);
		rd_cnt(v); `CHK(v, 16'h0006)
		stop <= 1'b0;
		pm.tick(0, 1);
		rd_cnt(v); `CHK(v, 16'h0007)
		wr(A_MAIN_CTRL, 8'h18);
		pm.tick(1, 2);
		rd(A_CNT_LO, q); `CHK(q, 8'h09)
		wr(A_CNT_LO, 8'h5a);
		rd(A_CNT_LO, q); `CHK(q, 8'h00)
		rd(A_CNT_HI, q);
		wr(A_MAIN_CTRL, 8'h08);
		repeat (20) @(posedge clk_i);
		wr(A_MAIN_CTRL, 8'h00);
		rd_cnt(v); `CHK(v != 16'h0000, 1'b1)
		// Modulus wrap, overflow flag, interrupt and flag clearing
		wr(A_MAIN_CTRL, 8'h10);
		wr(A_CNT_HI, 8'h00);
		wr(A_MOD_HI, 8'h00);
		wr(A_MOD_LO, 8'h04);
		pm.tick(0, 4);
		rd_cnt(v); `CHK(v, 16'h0004)
		rd(A_MAIN_CTRL, q); `CHK(q, 8'h10)
		pm.tick(0, 1);
		rd_cnt(v); `CHK(v, 16'h0000)
		rd(A_MAIN_CTRL, q); `CHK(q, 8'h90)
		`CHK(tof_irq_o, 1'b0)
		wr(A_MAIN_CTRL, 8'hd0);
		repeat (2) @(posedge clk_i);
		`CHK(tof_irq_o, 1'b1)
		rd(A_MAIN_CTRL, q);
		wr(A_MAIN_CTRL, 8'h50);
		rd(A_MAIN_CTRL, q); `CHK(q, 8'h50)
		`CHK(tof_irq_o, 1'b0)
		pm.tick(0, 5);
		rd(A_MAIN_CTRL, q); `CHK(q, 8'hd0)
		pm.tick(0, 5);
		wr(A_MAIN_CTRL, 8'h50);
		rd(A_MAIN_CTRL, q); `CHK(q, 8'hd0)
		wr(A_MAIN_CTRL, 8'h30);
		wr(A_CNT_LO, 8'h00);
		// Up/down counting between zero and the modulus
		for (int k = 0; k < 9; k++) begin
			pm.tick(0, 1);
			rd_cnt(v); `CHK(v, ud_exp[k])
			rd(A_MAIN_CTRL, q); `CHK(q, (k >= 4) ? 8'hb0 : 8'h30)
		end
		wr(A_MAIN_CTRL, 8'h10);
		wr(A_CNT_LO, 8'h00);
		// Input capture on each edge select code
		wr(C0 + A_CH_SC, 8'h44);
		pm.tick(0, 3);
		pm.set_pin(0, 1'b1);
		rd(C0 + A_CH_VH, h); `CHK(h, 8'h00)
		rd(C0 + A_CH_VL, q); `CHK(q, 8'h03)
		rd(C0 + A_CH_SC, q); `CHK(q, 8'hc4)
		`CHK(ch_irq_o[0], 1'b1)
		pm.set_pin(0, 1'b0);
		for (int e = 0; e < 4; e++) begin
			wr(C0 + A_CH_SC, 8'(e << 2));
			wr(A_CNT_LO, 8'h00);
			pm.set_pin(0, 1'b1);
			pm.tick(0, 2);
			pm.set_pin(0, 1'b0);
			pm.tick(0, 1);
			rd(C0 + A_CH_VH, h);
			rd(C0 + A_CH_VL, q); `CHK(q, cap_exp[e])
		end
		wr(A_CNT_LO, 8'h00);
		rd(C0 + A_CH_VH, h);
		pm.set_pin(0, 1'b1);
		rd(C0 + A_CH_VL, q); `CHK(q, 8'h02)
		rd(C0 + A_CH_VL, q); `CHK(q, 8'h00)
		rd(C0 + A_CH_VH, h);
		// Output compare actions and buffered value load
		wr(C1 + A_CH_SC, 8'h1c);
		wr(C1 + A_CH_VH, 8'h00);
		wr(C1 + A_CH_VL, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(C1 + A_CH_SC, 8'h10 | 8'(oc_els[i] << 2));
			wr(A_CNT_LO, 8'h00);
			// Match is taken on the tick that leaves the compare value
			pm.tick(0, 4);
			`CHK(ch_pin_o[1], oc_pin[i])
			`CHK(ch_oe_o[1], 1'b1)
		end
		rd(C1 + A_CH_SC, q); `CHK(q[7], 1'b1)
		wr(C1 + A_CH_SC, 8'h14);
		wr(C1 + A_CH_VL, 8'h01);
		wr(A_CNT_LO, 8'h00);
		pm.tick(0, 2);
		`CHK(ch_pin_o[1], 1'b0)
		wr(C1 + A_CH_VH, 8'h00);
		wr(A_CNT_LO, 8'h00);
		pm.tick(0, 2);
		`CHK(ch_pin_o[1], 1'b1)
		summarize();
	end
endmodule
